// file: design/l3b_cache_bank.sv
// Purpose: one cache bank with tree replacement and two atomic engines
// Assumes: requester keeps credits and forms atomic packets
// Notes: cache path answers one cycle after taking; banked path three, four after a bubble
// Overview of operation
// R01: 64-byte lines; banked part gives sixteen dwords
// R02: Every operation taken once per clock
// R03: Tag holds 32-bit address, two-bit state; the code keeps only address bits 31:8 as a 24-bit tag
// R04: Destination field steers to one of four
// R05: Miss reserves nothing; allocate on fill
// R06: Dirty victim evicted to super queue first
// R07: Per-partition force vectors restrict tree victims
// R08: Forced tree nodes keep value on update
// R09: Enabled partitions need ways; disabled stay silent
// R10: Bitwise and move act on one word
// R11: Arithmetic atomics return prior, predecrement new
// R12: Max and min store chosen extreme
// R13: Compare-write stores second operand on match
// R14: Atomicity per 32-bit word only
// R15: Two engines: cache path and banked memory
// R16: Atomic enables only target dword lanes
// R17: Atomics take queue and atomic credits
// R18: Operands sit in dword 0 and 1
// R19: Cache atomic result replicated across sixteen dwords
// R20: Banked path stalls requester when not ready
// R21: Same-bank back-to-back atomics get one bubble
// R22: Banked atomic answered on its enabled lane
`timescale 1ns/100ps
module l3b_cache_bank (
	input wire logic clk, // 40 MHz clock
	input wire logic rst, // Asynchronous reset, active high
	l3b_link_if.device link, // Requests in, answers and evictions out
	input wire logic [l3b_pkg::NODES-1:0] force_sel [l3b_pkg::PARTS], // Forced nodes per part
	input wire logic [l3b_pkg::NODES-1:0] force_val [l3b_pkg::PARTS] // Forced values per part
);
	import l3b_pkg::*;

	typedef struct packed {
		logic ready;
		logic rsp_valid;
		logic rsp_hit;
		logic rsp_atomic;
		logic [LINE_BITS-1:0] rsp_data;
		logic ev_valid;
		logic [ADDR_BITS-1:0] ev_addr;
		logic [LINE_BITS-1:0] ev_data;
		l3b_slot_t s1;
		l3b_slot_t s2;
		logic [LINE_BITS-1:0] s2_old;
		logic bm_valid;
		logic bm_atomic;
		logic [LINE_BITS-1:0] bm_data;
	} l3b_bank_t;

	l3b_bank_t st_reg;
	l3b_bank_t st_next;

	logic [TAG_BITS-1:0] tag_mem [SETS][WAYS];
	l3b_lstate_t line_state [SETS][WAYS];
	logic [LINE_BITS-1:0] data_mem [SETS][WAYS];
	logic [NODES-1:0] plru_mem [SETS];
	logic [DW_BITS-1:0] bm_mem [LANES][BM_WORDS];

	l3b_req_t rq;
	logic c_take;
	logic b_take;
	logic [SET_BITS-1:0] c_set;
	logic [TAG_BITS-1:0] c_tag;
	logic c_hit;
	logic [WAY_BITS-1:0] c_hway;
	logic [WAY_BITS-1:0] c_vic;
	logic [WAY_BITS-1:0] c_way;
	logic [NODES-1:0] c_eff;
	logic [LINE_BITS-1:0] c_line;
	logic [LINE_BITS-1:0] c_wline;
	logic [LANE_BITS-1:0] c_lane;
	logic [DW_BITS-1:0] c_new;
	logic [DW_BITS-1:0] c_ret;
	logic c_awe;
	logic c_wr;
	logic c_touch;
	logic c_evict;
	l3b_lstate_t c_state;
	logic [LANE_BITS-1:0] b_lane;
	logic [DW_BITS-1:0] b_new;
	logic [DW_BITS-1:0] b_ret;
	logic b_awe;
	logic [LANES-1:0] b_we;
	logic [DW_BITS-1:0] b_wd [LANES];
	logic [LINE_BITS-1:0] b_out;
	logic [LINE_BITS-1:0] b_rd;

	assign rq = link.req;
	assign c_take = link.req_valid && st_reg.ready && rq.dest != DST_BANKED_LOCAL_MEMORY; // [R04]
	assign b_take = link.req_valid && st_reg.ready && rq.dest == DST_BANKED_LOCAL_MEMORY; // [R04]

	l3b_atomic_alu u_cache_alu ( // [R15]
		.op(rq.atop),
		.old_val(c_line[c_lane*DW_BITS+:DW_BITS]), // [R14]
		.first_operand(rq.data[0+:DW_BITS]), // [R18]
		.second_operand(rq.data[DW_BITS+:DW_BITS]), // [R18]
		.new_val(c_new),
		.ret_val(c_ret),
		.write_en(c_awe)
	);

	l3b_atomic_alu u_banked_alu ( // [R15]
		.op(st_reg.s2.req.atop),
		.old_val(st_reg.s2_old[b_lane*DW_BITS+:DW_BITS]),
		.first_operand(st_reg.s2.req.data[0+:DW_BITS]),
		.second_operand(st_reg.s2.req.data[DW_BITS+:DW_BITS]),
		.new_val(b_new),
		.ret_val(b_ret),
		.write_en(b_awe)
	);

	// Cache path lookup, fill allocation and atomics
	always_comb begin
		c_set = rq.addr[SET_LSB+:SET_BITS];
		c_tag = rq.addr[TAG_LSB+:TAG_BITS]; // [R03]
		c_hit = 1'b0;
		c_hway = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (line_state[c_set][w] != LS_INVALID && tag_mem[c_set][w] == c_tag) begin
				c_hit = 1'b1;
				c_hway = WAY_BITS'(w);
			end
		end
		c_eff = (plru_mem[c_set] & ~force_sel[rq.part]) | (force_val[rq.part] & force_sel[rq.part]); // [R07]
		c_vic = plru_victim(c_eff); // [R07]
		c_way = (rq.op == OP_FILL && !c_hit) ? c_vic : c_hway;
		c_line = data_mem[c_set][c_way];
		c_lane = l3b_first_lane(rq.be);
		c_wline = c_line;
		c_state = LS_DIRTY;
		c_wr = 1'b0;
		unique case (rq.op)
			OP_READ: c_wr = 1'b0;
			OP_WRITE: begin
				c_wr = c_hit; // [R05]
				for (int b = 0; b < LINE_BYTES; b++) begin
					if (rq.be[b]) begin
						c_wline[b*BYTE_BITS+:BYTE_BITS] = rq.data[b*BYTE_BITS+:BYTE_BITS];
					end
				end
			end
			OP_ATOMIC: begin
				c_wr = c_hit && c_awe;
				c_wline[c_lane*DW_BITS+:DW_BITS] = c_new;
			end
			OP_FILL: begin
				c_wr = !c_hit; // [R05]
				c_wline = rq.data; // [R01]
				c_state = LS_CLEAN; // [R06]
			end
		endcase
		c_wr = c_wr && c_take; // [R02]
		c_touch = c_take && (c_hit || rq.op == OP_FILL);
		c_evict = c_take && rq.op == OP_FILL && !c_hit && line_state[c_set][c_vic] == LS_DIRTY; // [R06]
	end

	// Banked path: second stage writes and answers
	always_comb begin
		b_lane = l3b_first_lane(st_reg.s2.req.be);
		b_out = '0;
		for (int l = 0; l < LANES; l++) begin
			b_we[l] = 1'b0;
			b_wd[l] = st_reg.s2_old[l*DW_BITS+:DW_BITS];
			b_rd[l*DW_BITS+:DW_BITS] = bm_mem[l][st_reg.s1.req.bm_addr[l*BM_AW+:BM_AW]];
			for (int b = 0; b < LANE_BYTES; b++) begin
				if (st_reg.s2.req.be[l*LANE_BYTES+b]) begin
					b_wd[l][b*BYTE_BITS+:BYTE_BITS] = st_reg.s2.req.data[(l*LANE_BYTES+b)*BYTE_BITS+:BYTE_BITS];
				end
			end
			if (st_reg.s2.valid && st_reg.s2.req.op == OP_WRITE) begin
				b_we[l] = |st_reg.s2.req.be[l*LANE_BYTES+:LANE_BYTES];
			end
			if (st_reg.s2.valid && st_reg.s2.req.op == OP_READ && st_reg.s2.req.be[l*LANE_BYTES]) begin
				b_out[l*DW_BITS+:DW_BITS] = st_reg.s2_old[l*DW_BITS+:DW_BITS];
			end
		end
		if (st_reg.s2.valid && st_reg.s2.req.op == OP_ATOMIC) begin
			b_we[b_lane] = b_awe; // [R14]
			b_wd[b_lane] = b_new;
			b_out[b_lane*DW_BITS+:DW_BITS] = b_ret; // [R22]
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.rsp_valid = c_take;
		st_next.rsp_hit = c_hit;
		st_next.rsp_atomic = c_take && rq.op == OP_ATOMIC;
		st_next.rsp_data = (rq.op == OP_ATOMIC) ? {LANES{c_ret}} : c_line; // [R19]
		st_next.ev_valid = c_evict; // [R06]
		if (c_evict) begin
			st_next.ev_addr = {tag_mem[c_set][c_vic], c_set, {SET_LSB{1'b0}}};
			st_next.ev_data = c_line;
		end
		st_next.s2.valid = st_reg.s1.valid && !bm_hazard(st_reg.s1, st_reg.s2); // [R21]
		st_next.s2.req = st_reg.s1.req;
		st_next.s2_old = b_rd;
		if (b_take) begin
			st_next.s1.valid = 1'b1;
			st_next.s1.req = rq;
		end else if (st_next.s2.valid) begin
			st_next.s1.valid = 1'b0;
		end
		st_next.ready = !bm_hazard(st_next.s1, st_next.s2); // [R20]
		st_next.bm_valid = st_reg.s2.valid;
		st_next.bm_atomic = st_reg.s2.valid && st_reg.s2.req.op == OP_ATOMIC;
		st_next.bm_data = b_out;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int s = 0; s < SETS; s++) begin
				plru_mem[s] <= '0;
				for (int w = 0; w < WAYS; w++) begin
					line_state[s][w] <= LS_INVALID;
				end
			end
		end else begin
			if (c_wr) begin
				line_state[c_set][c_way] <= c_state; // [R03]
			end
			if (c_touch) begin
				plru_mem[c_set] <= plru_touch(plru_mem[c_set], force_sel[rq.part], c_way); // [R08]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (c_wr) begin
			data_mem[c_set][c_way] <= c_wline; // [R05]
			tag_mem[c_set][c_way] <= c_tag;
		end
		for (int l = 0; l < LANES; l++) begin
			if (b_we[l]) begin
				bm_mem[l][st_reg.s2.req.bm_addr[l*BM_AW+:BM_AW]] <= b_wd[l]; // [R01]
			end
		end
	end

	assign link.req_ready = st_reg.ready;
	assign link.rsp_valid = st_reg.rsp_valid;
	assign link.rsp_hit = st_reg.rsp_hit;
	assign link.rsp_atomic = st_reg.rsp_atomic;
	assign link.rsp_data = st_reg.rsp_data;
	assign link.bm_rsp_valid = st_reg.bm_valid;
	assign link.bm_rsp_atomic = st_reg.bm_atomic;
	assign link.bm_rsp_data = st_reg.bm_data;
	assign link.ev_valid = st_reg.ev_valid;
	assign link.ev_addr = st_reg.ev_addr;
	assign link.ev_data = st_reg.ev_data;
endmodule // l3b_cache_bank

// file: design/l3b_pkg.sv
// Purpose: shared constants, types and helpers for the cache bank link
// Assumes: one clock domain, one request per cycle on the link
// Notes: the 48-way tree has 47 nodes: root, 32-way left, 16-way right
package l3b_pkg;
	localparam int LINE_BITS = 512;
	localparam int LINE_BYTES = 64;
	localparam int BYTE_BITS = 8;
	localparam int DW_BITS = 32;
	localparam int LANES = 16;
	localparam int LANE_BITS = 4;
	localparam int LANE_BYTES = 4;
	localparam int ADDR_BITS = 32;
	localparam int SETS = 4;
	localparam int SET_LSB = 6;
	localparam int SET_BITS = 2;
	localparam int TAG_LSB = 8;
	localparam int TAG_BITS = 24;
	localparam int WAYS = 48;
	localparam int WAY_BITS = 6;
	localparam int NODES = 47;
	localparam int LEFT_WAYS = 32;
	localparam int LEFT_BASE = 1;
	localparam int LEFT_DEPTH = 5;
	localparam int RIGHT_BASE = 32;
	localparam int RIGHT_DEPTH = 4;
	localparam int PARTS = 4;
	localparam int PART_BITS = 2;
	localparam int BM_AW = 10;
	localparam int BM_WORDS = 1024;
	localparam int SQ_CREDITS = 16;
	localparam int ATOM_CREDITS = 8;
	localparam int CRED_BITS = 5;
	localparam logic [DW_BITS-1:0] DW_ONE = 32'h0000_0001;

	typedef enum logic [1:0] {
		DST_CACHE = 2'h0,
		DST_RETURN_BUFFER_SPACE = 2'h1,
		DST_STATE_ARBITER = 2'h2,
		DST_BANKED_LOCAL_MEMORY = 2'h3
	} l3b_dest_t;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_WRITE = 2'h1,
		OP_ATOMIC = 2'h2,
		OP_FILL = 2'h3
	} l3b_op_t;

	typedef enum logic [3:0] {
		ATOMIC_AND = 4'h0,
		ATOMIC_OR = 4'h1,
		ATOMIC_XOR = 4'h2,
		ATOMIC_MOVE = 4'h3,
		ATOMIC_INCREMENT = 4'h4,
		ATOMIC_DECREMENT = 4'h5,
		ATOMIC_ADD = 4'h6,
		ATOMIC_SUBTRACT = 4'h7,
		ATOMIC_REVERSE_SUBTRACT = 4'h8,
		ATOMIC_SIGNED_MAX = 4'h9,
		ATOMIC_SIGNED_MIN = 4'hA,
		ATOMIC_UNSIGNED_MAX = 4'hB,
		ATOMIC_UNSIGNED_MIN = 4'hC,
		ATOMIC_COMPARE_WRITE = 4'hD,
		ATOMIC_PREDECREMENT = 4'hE
	} l3b_atop_t;

	typedef enum logic [1:0] {
		LS_INVALID = 2'h0,
		LS_CLEAN = 2'h1,
		LS_DIRTY = 2'h2
	} l3b_lstate_t;

	typedef struct packed {
		l3b_dest_t dest;
		l3b_op_t op;
		l3b_atop_t atop;
		logic [PART_BITS-1:0] part;
		logic [ADDR_BITS-1:0] addr;
		logic [LINE_BYTES-1:0] be;
		logic [LINE_BITS-1:0] data;
		logic [LANES*BM_AW-1:0] bm_addr;
	} l3b_req_t;

	typedef struct packed {
		logic valid;
		l3b_req_t req;
	} l3b_slot_t;

	// Lowest dword lane with any byte enabled
	function automatic logic [LANE_BITS-1:0] l3b_first_lane(input logic [LINE_BYTES-1:0] be);
		logic [LANE_BITS-1:0] lane;
		lane = '0;
		for (int l = LANES - 1; l >= 0; l--) begin
			if (|be[l*LANE_BYTES+:LANE_BYTES]) begin
				lane = LANE_BITS'(l);
			end
		end
		return lane;
	endfunction

	function automatic logic [LANES-1:0] l3b_lane_mask(input logic [LINE_BYTES-1:0] be);
		logic [LANES-1:0] m;
		for (int l = 0; l < LANES; l++) begin
			m[l] = |be[l*LANE_BYTES+:LANE_BYTES];
		end
		return m;
	endfunction

	// Victim walk over the forced tree; node value 1 points right
	function automatic logic [WAY_BITS-1:0] plru_victim(input logic [NODES-1:0] e);
		logic [WAY_BITS-1:0] leaf;
		int idx;
		int base;
		int depth;
		logic b;
		leaf = '0;
		idx = 0;
		base = e[0] ? RIGHT_BASE : LEFT_BASE;
		depth = e[0] ? RIGHT_DEPTH : LEFT_DEPTH;
		for (int i = 0; i < LEFT_DEPTH; i++) begin
			if (i < depth) begin
				b = e[base+idx];
				leaf = {leaf[WAY_BITS-2:0], b};
				idx = 2 * idx + 1 + int'(b);
			end
		end
		return e[0] ? leaf + WAY_BITS'(LEFT_WAYS) : leaf;
	endfunction

	// Point the path away from the used way, sparing forced nodes
	function automatic logic [NODES-1:0] plru_touch(input logic [NODES-1:0] p,
			input logic [NODES-1:0] f, input logic [WAY_BITS-1:0] way);
		logic [NODES-1:0] n;
		logic right;
		logic [WAY_BITS-1:0] leaf;
		int idx;
		int base;
		int depth;
		logic b;
		n = p;
		right = way >= WAY_BITS'(LEFT_WAYS);
		if (!f[0]) begin
			n[0] = !right; // [R08]
		end
		leaf = right ? way - WAY_BITS'(LEFT_WAYS) : way;
		base = right ? RIGHT_BASE : LEFT_BASE;
		depth = right ? RIGHT_DEPTH : LEFT_DEPTH;
		idx = 0;
		for (int i = 0; i < LEFT_DEPTH; i++) begin
			if (i < depth) begin
				b = leaf[depth-1-i];
				if (!f[base+idx]) begin
					n[base+idx] = !b; // [R08]
				end
				idx = 2 * idx + 1 + int'(b);
			end
		end
		return n;
	endfunction

	// Banked read in the first stage races a write in the second
	function automatic logic bm_hazard(input l3b_slot_t a, input l3b_slot_t b);
		return a.valid && b.valid && (b.req.op == OP_WRITE || b.req.op == OP_ATOMIC)
			&& |(l3b_lane_mask(a.req.be) & l3b_lane_mask(b.req.be));
	endfunction
endpackage

// file: design/l3b_link_if.sv
// Purpose: link between the requester end and the cache bank end
// Assumes: both ends on clk, reset by rst
// Notes: cache answers and banked memory answers have their own channels
`timescale 1ns/100ps
interface l3b_link_if (
	input wire logic clk, // Shared clock
	input wire logic rst // Shared reset
);
	import l3b_pkg::*;
	logic req_valid;
	logic req_ready;
	l3b_req_t req;
	logic rsp_valid;
	logic rsp_hit;
	logic rsp_atomic;
	logic [LINE_BITS-1:0] rsp_data;
	logic bm_rsp_valid;
	logic bm_rsp_atomic;
	logic [LINE_BITS-1:0] bm_rsp_data;
	logic ev_valid;
	logic [ADDR_BITS-1:0] ev_addr;
	logic [LINE_BITS-1:0] ev_data;

	modport device (
		input req_valid, req,
		output req_ready, rsp_valid, rsp_hit, rsp_atomic, rsp_data,
		output bm_rsp_valid, bm_rsp_atomic, bm_rsp_data, ev_valid, ev_addr, ev_data
	);
	modport host (
		output req_valid, req,
		input req_ready, rsp_valid, rsp_hit, rsp_atomic, rsp_data,
		input bm_rsp_valid, bm_rsp_atomic, bm_rsp_data, ev_valid, ev_addr, ev_data
	);
endinterface

// file: design/l3b_atomic_alu.sv
// Purpose: single-dword atomic engine
// Assumes: operands already placed in dword positions by the caller
// Notes: write_en low means memory keeps the old value
`timescale 1ns/100ps
module l3b_atomic_alu (
	input l3b_pkg::l3b_atop_t op, // Atomic operation
	input wire logic [l3b_pkg::DW_BITS-1:0] old_val, // Prior destination value
	input wire logic [l3b_pkg::DW_BITS-1:0] first_operand, // First operand
	input wire logic [l3b_pkg::DW_BITS-1:0] second_operand, // Second operand
	output logic [l3b_pkg::DW_BITS-1:0] new_val, // Value to store
	output logic [l3b_pkg::DW_BITS-1:0] ret_val, // Value to return
	output logic write_en // Store new_val
);
	import l3b_pkg::*;
	always_comb begin
		new_val = old_val;
		ret_val = old_val;
		write_en = 1'b1;
		unique case (op)
			ATOMIC_AND: new_val = old_val & first_operand; // [R10]
			ATOMIC_OR: new_val = old_val | first_operand; // [R10]
			ATOMIC_XOR: new_val = old_val ^ first_operand; // [R10]
			ATOMIC_MOVE: new_val = first_operand; // [R10]
			ATOMIC_INCREMENT: new_val = old_val + DW_ONE; // [R11]
			ATOMIC_DECREMENT: new_val = old_val - DW_ONE; // [R11]
			ATOMIC_ADD: new_val = old_val + first_operand; // [R11]
			ATOMIC_SUBTRACT: new_val = old_val - first_operand; // [R11]
			ATOMIC_REVERSE_SUBTRACT: new_val = first_operand - old_val; // [R11]
			ATOMIC_SIGNED_MAX: new_val = ($signed(old_val) > $signed(first_operand)) ? old_val : first_operand; // [R12]
			ATOMIC_SIGNED_MIN: new_val = ($signed(old_val) < $signed(first_operand)) ? old_val : first_operand; // [R12]
			ATOMIC_UNSIGNED_MAX: new_val = (old_val > first_operand) ? old_val : first_operand; // [R12]
			ATOMIC_UNSIGNED_MIN: new_val = (old_val < first_operand) ? old_val : first_operand; // [R12]
			ATOMIC_COMPARE_WRITE: begin
				write_en = (first_operand == old_val); // [R13]
				new_val = write_en ? second_operand : old_val; // [R13]
			end
			ATOMIC_PREDECREMENT: begin
				new_val = old_val - DW_ONE; // [R11]
				ret_val = old_val - DW_ONE; // [R11]
			end
			default: write_en = 1'b0;
		endcase
	end
endmodule // l3b_atomic_alu

// file: design/l3b_requester.sv
// Purpose: arbiter end: credits, packet shaping, answer and write-out ports
// Assumes: clients hold requests until taken
// Notes: two-entry queue keeps one request per clock with a registered ready
`timescale 1ns/100ps
module l3b_requester (
	input wire logic clk, // 40 MHz clock
	input wire logic rst, // Asynchronous reset, active high
	l3b_link_if.host link, // Link to the cache bank
	input wire logic cl_valid, // Client request valid
	output logic cl_ready, // Client request taken when both high
	input l3b_pkg::l3b_req_t cl_req, // Client request packet
	input wire logic [l3b_pkg::PARTS-1:0] part_enable, // Enabled partitions
	output logic rsp_valid, // Cache answer valid
	output logic rsp_hit, // Cache answer was a hit
	output logic [l3b_pkg::LINE_BITS-1:0] rsp_data, // Cache answer line
	output logic bm_rsp_valid, // Banked memory answer valid
	output logic [l3b_pkg::LINE_BITS-1:0] bm_rsp_data, // Banked memory answer line
	output logic wb_valid, // Dirty line write-out valid
	output logic [l3b_pkg::ADDR_BITS-1:0] wb_addr, // Write-out line address
	output logic [l3b_pkg::LINE_BITS-1:0] wb_data // Write-out line data
);
	import l3b_pkg::*;

	typedef struct packed {
		l3b_slot_t q0;
		l3b_slot_t q1;
		logic cl_ready;
		logic [CRED_BITS-1:0] sq_cred;
		logic [CRED_BITS-1:0] at_cred;
		logic rsp_valid;
		logic rsp_hit;
		logic [LINE_BITS-1:0] rsp_data;
		logic bm_valid;
		logic [LINE_BITS-1:0] bm_data;
		logic wb_valid;
		logic [ADDR_BITS-1:0] wb_addr;
		logic [LINE_BITS-1:0] wb_data;
	} l3b_host_t;

	localparam l3b_host_t HOST_RST = '{
		sq_cred: CRED_BITS'(SQ_CREDITS),
		at_cred: CRED_BITS'(ATOM_CREDITS),
		default: '0
	};

	l3b_host_t st_reg;
	l3b_host_t st_next;
	l3b_req_t shaped;
	logic [LANE_BITS-1:0] lane;
	logic fwd;
	logic is_atomic;

	always_comb begin
		st_next = st_reg;
		shaped = cl_req;
		lane = l3b_first_lane(cl_req.be);
		is_atomic = cl_req.op == OP_ATOMIC;
		if (is_atomic) begin
			shaped.be = '0;
			shaped.be[lane*LANE_BYTES+:LANE_BYTES] = cl_req.be[lane*LANE_BYTES+:LANE_BYTES]; // [R16] [R22]
		end
		fwd = cl_valid && st_reg.cl_ready && part_enable[cl_req.part]; // [R09]
		if (st_reg.q0.valid && link.req_ready) begin
			st_next.q0 = st_reg.q1;
			st_next.q1.valid = 1'b0;
		end
		if (fwd && !st_next.q0.valid) begin
			st_next.q0 = '{valid: 1'b1, req: shaped};
		end else if (fwd) begin
			st_next.q1 = '{valid: 1'b1, req: shaped};
		end
		st_next.sq_cred = st_reg.sq_cred - CRED_BITS'(fwd) + CRED_BITS'(link.rsp_valid)
			+ CRED_BITS'(link.bm_rsp_valid); // [R17]
		st_next.at_cred = st_reg.at_cred - CRED_BITS'(fwd && is_atomic)
			+ CRED_BITS'(link.rsp_valid && link.rsp_atomic)
			+ CRED_BITS'(link.bm_rsp_valid && link.bm_rsp_atomic); // [R17]
		st_next.cl_ready = !st_next.q1.valid && st_next.sq_cred != '0 && st_next.at_cred != '0; // [R17]
		st_next.rsp_valid = link.rsp_valid;
		st_next.rsp_hit = link.rsp_hit;
		st_next.rsp_data = link.rsp_data;
		st_next.bm_valid = link.bm_rsp_valid;
		st_next.bm_data = link.bm_rsp_data;
		st_next.wb_valid = link.ev_valid;
		st_next.wb_addr = link.ev_addr;
		st_next.wb_data = link.ev_data;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= HOST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.req_valid = st_reg.q0.valid;
	assign link.req = st_reg.q0.req; // [R18] [R04]
	assign cl_ready = st_reg.cl_ready;
	assign rsp_valid = st_reg.rsp_valid;
	assign rsp_hit = st_reg.rsp_hit;
	assign rsp_data = st_reg.rsp_data;
	assign bm_rsp_valid = st_reg.bm_valid;
	assign bm_rsp_data = st_reg.bm_data;
	assign wb_valid = st_reg.wb_valid;
	assign wb_addr = st_reg.wb_addr;
	assign wb_data = st_reg.wb_data;
endmodule // l3b_requester

// file: tb/l3b_link_assertions.sv
// Purpose: timing checks on the link between requester and cache bank
// Assumes: one clock, reset active high
// Notes: watches link signals only
`timescale 1ns/100ps
module l3b_link_assertions (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic req_valid, // Request valid
	input wire logic req_ready, // Request ready
	input l3b_pkg::l3b_req_t req, // Request packet
	input wire logic rsp_valid, // Cache answer
	input wire logic rsp_hit, // Cache hit
	input wire logic rsp_atomic, // Atomic answer
	input wire logic [l3b_pkg::LINE_BITS-1:0] rsp_data, // Answer line
	input wire logic bm_rsp_valid, // Banked answer
	input wire logic ev_valid, // Eviction
	input wire logic [l3b_pkg::ADDR_BITS-1:0] ev_addr // Eviction address
);
	import l3b_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_bm_take;
		s_take ##0 req.dest == DST_BANKED_LOCAL_MEMORY;
	endsequence
	sequence s_bm_atom;
		s_bm_take ##0 req.op == OP_ATOMIC;
	endsequence
	a_cache_answer_next: assert property (s_take ##0 req.dest != DST_BANKED_LOCAL_MEMORY
		|=> rsp_valid) else $error("cache answer late");
	a_rsp_has_cause: assert property (rsp_valid
		|-> $past(req_valid && req_ready && req.dest != DST_BANKED_LOCAL_MEMORY))
		else $error("cache answer without request");
	a_bm_answer_bound: assert property (s_bm_take |-> ##[3:4] bm_rsp_valid)
		else $error("banked answer missing");
	a_atomic_replicated: assert property (rsp_valid && rsp_atomic
		|-> rsp_data == {LANES{rsp_data[DW_BITS-1:0]}}) else $error("atomic not replicated");
	a_evict_with_fill: assert property (ev_valid
		|-> rsp_valid && !rsp_hit && $past(req.op) == OP_FILL) else $error("stray eviction");
	a_evict_line_aligned: assert property (ev_valid |-> ev_addr[5:0] == 6'h00)
		else $error("eviction address unaligned");
	a_miss_no_alloc: assert property (rsp_valid && $past(req.op) != OP_FILL
		|-> !ev_valid) else $error("allocation outside fill");
	a_bank_bubble: assert property (s_bm_atom ##1 (s_bm_atom ##0 req.be == $past(req.be))
		|=> !req_ready) else $error("no bubble on same bank");
endmodule // l3b_link_assertions

// file: tb/l3_bank_plru_atomics_tb_top.sv
// Purpose: requester and cache bank joined, driven from the client side
// Assumes: partition 3 forces every node left, partition 2 disabled
// Notes: expectations queued by the driver, compared by monitors
`timescale 1ns/100ps
module l3_bank_plru_atomics_tb_top;
	import l3b_pkg::*;
	typedef struct packed {
		logic hit;
		logic [31:0] a;
		logic [LINE_BITS-1:0] d;
		logic [LINE_BITS-1:0] m;
	} l3b_note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cl_valid = 1'b0;
	logic cl_ready, rsp_valid, rsp_hit, bm_rsp_valid, wb_valid;
	l3b_req_t cl_req = '0;
	logic [PARTS-1:0] part_enable = 4'hB;
	logic [LINE_BITS-1:0] rsp_data, bm_rsp_data, wb_data, ln, d;
	logic [ADDR_BITS-1:0] wb_addr;
	logic [NODES-1:0] force_sel [PARTS] = '{'0, '0, '0, '1};
	logic [NODES-1:0] force_val [PARTS] = '{'0, '0, '0, '0};
	logic [15:0] lf = 16'hC134;
	logic [31:0] x, a, b, bw;
	logic [63:0] r;
	l3b_note_t cq[$], bq[$], wq[$], n;
	int fails = 0;
	int checks_done = 0;
	always #12.5 clk = ~clk;
	l3b_link_if l3b_link_if_inst (.clk(clk), .rst(rst));
	l3b_requester l3b_requester_inst (.clk(clk), .rst(rst), .link(l3b_link_if_inst),
		.cl_valid(cl_valid), .cl_ready(cl_ready), .cl_req(cl_req), .part_enable(part_enable),
		.rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data),
		.bm_rsp_valid(bm_rsp_valid), .bm_rsp_data(bm_rsp_data), .wb_valid(wb_valid),
		.wb_addr(wb_addr), .wb_data(wb_data));
	l3b_cache_bank l3b_cache_bank_inst (.clk(clk), .rst(rst), .link(l3b_link_if_inst),
		.force_sel(force_sel), .force_val(force_val));
	l3b_link_assertions l3b_link_assertions_inst (.clk(clk), .rst(rst),
		.req_valid(l3b_link_if_inst.req_valid), .req_ready(l3b_link_if_inst.req_ready),
		.req(l3b_link_if_inst.req), .rsp_valid(l3b_link_if_inst.rsp_valid),
		.rsp_hit(l3b_link_if_inst.rsp_hit), .rsp_atomic(l3b_link_if_inst.rsp_atomic),
		.rsp_data(l3b_link_if_inst.rsp_data), .bm_rsp_valid(l3b_link_if_inst.bm_rsp_valid),
		.ev_valid(l3b_link_if_inst.ev_valid), .ev_addr(l3b_link_if_inst.ev_addr));
	function logic [31:0] rnd();
		for (int i = 0; i < 32; i++) begin
			lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
			rnd[i] = lf[0];
		end
	endfunction
	// Returns {new value, returned value}
	function automatic logic [63:0] am(l3b_atop_t o, logic [31:0] v, p, q);
		case (o)
			ATOMIC_AND: return {v & p, v};
			ATOMIC_OR: return {v | p, v};
			ATOMIC_XOR: return {v ^ p, v};
			ATOMIC_MOVE: return {p, v};
			ATOMIC_INCREMENT: return {v + 32'h1, v};
			ATOMIC_DECREMENT: return {v - 32'h1, v};
			ATOMIC_ADD: return {v + p, v};
			ATOMIC_SUBTRACT: return {v - p, v};
			ATOMIC_REVERSE_SUBTRACT: return {p - v, v};
			ATOMIC_SIGNED_MAX: return {($signed(v) > $signed(p)) ? v : p, v};
			ATOMIC_SIGNED_MIN: return {($signed(v) < $signed(p)) ? v : p, v};
			ATOMIC_UNSIGNED_MAX: return {(v > p) ? v : p, v};
			ATOMIC_UNSIGNED_MIN: return {(v < p) ? v : p, v};
			ATOMIC_COMPARE_WRITE: return {(p == v) ? q : v, v};
			default: return {v - 32'h1, v - 32'h1};
		endcase
	endfunction
	task automatic check(input logic [LINE_BITS-1:0] s, input logic [LINE_BITS-1:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Drive one request; k 0 cache note, 1 banked note, else none
	task automatic send(input l3b_dest_t ds, input l3b_op_t op, input logic [3:0] at,
		input logic [1:0] pt, input logic [31:0] ad, input logic [63:0] be, input l3b_note_t e,
		input int k);
		int i;
		cl_req = '{ds, op, l3b_atop_t'(at), pt, ad, be, d, {LANES{10'h2A}}};
		cl_valid = 1'b1;
		for (i = 0; i < 200 && cl_ready !== 1'b1; i++) @(negedge clk);
		if (i == 200) begin
			fails++;
			summarize();
		end
		if (k == 0) cq.push_back(e);
		if (k == 1) bq.push_back(e);
		@(negedge clk);
	endtask
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			n = cq.size() ? cq.pop_front() : '1;
			check(LINE_BITS'(rsp_hit), LINE_BITS'(n.hit));
			check(rsp_data & n.m, n.d & n.m);
		end
		if (bm_rsp_valid === 1'b1) begin
			n = bq.size() ? bq.pop_front() : '1;
			check(bm_rsp_data & n.m, n.d & n.m);
		end
		if (wb_valid === 1'b1) begin
			n = wq.size() ? wq.pop_front() : '1;
			check(LINE_BITS'(wb_addr), LINE_BITS'(n.a));
			check(wb_data, n.d);
		end
	end
	initial begin
		for (int i = 0; i < LANES; i++) d[32*i+:32] = rnd();
		repeat (6) @(negedge clk);
		rst = 1'b0;
		send(DST_CACHE, OP_READ, 0, 3, 32'h1040, '1, '0, 0);
		send(DST_CACHE, OP_FILL, 0, 3, 32'h1040, '1, '0, 0);
		ln = d;
		send(DST_CACHE, OP_READ, 0, 3, 32'h1040, '1, '{1'b1, 0, ln, '1}, 0);
		d[95:64] = rnd();
		ln[95:64] = d[95:64];
		send(DST_RETURN_BUFFER_SPACE, OP_WRITE, 0, 3, 32'h1048, 64'hF00,
			'{1'b1, 0, ln, '0}, 0);
		for (int i = 0; i < 16; i++) begin
			x = ln[32*i+:32];
			a = (i == 13) ? x : rnd();
			b = rnd();
			d[63:0] = {b, a};
			r = am(l3b_atop_t'((i == 15) ? 13 : i), x, a, b);
			ln[32*i+:32] = r[63:32];
			send(DST_CACHE, OP_ATOMIC, (i == 15) ? 13 : i, 3, 32'h1040 + 4 * i,
				64'hF << (4 * i), '{1'b1, 0, {LANES{r[31:0]}}, '1}, 0);
		end
		send(DST_CACHE, OP_READ, 0, 3, 32'h1040, '1, '{1'b1, 0, ln, '1}, 0);
		wq.push_back('{1'b0, 32'h1040, ln, '0});
		send(DST_CACHE, OP_FILL, 0, 3, 32'h2040, '1, '0, 0);
		send(DST_CACHE, OP_READ, 0, 3, 32'h1040, '1, '0, 0);
		send(DST_CACHE, OP_READ, 0, 2, 32'h1040, '1, '0, 2);
		bw = rnd();
		d[255:224] = bw;
		send(DST_BANKED_LOCAL_MEMORY, OP_WRITE, 0, 3, 0, 64'hF << 28, '0, 1);
		// Drain the pipe so the first two atomics go back to back
		cl_valid = 1'b0;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 15; i++) begin
			a = (i == 13) ? bw : rnd();
			b = rnd();
			d[63:0] = {b, a};
			r = am(l3b_atop_t'(i), bw, a, b);
			bw = r[63:32];
			send(DST_BANKED_LOCAL_MEMORY, OP_ATOMIC, i, 3, 28, 64'hF << 28,
				'{1'b0, 0, LINE_BITS'(r[31:0]) << 224, '1}, 1);
		end
		send(DST_BANKED_LOCAL_MEMORY, OP_READ, 0, 3, 0, 64'hF << 28,
			'{1'b0, 0, LINE_BITS'(bw) << 224, '1}, 1);
		cl_valid = 1'b0;
		repeat (20) @(negedge clk);
		check(LINE_BITS'(cq.size() + bq.size() + wq.size()), '0);
		summarize();
	end
endmodule // l3_bank_plru_atomics_tb_top
